// [rtl/rtsup_top.sv]
// supervisor support: watchdog, square wave, reset output, calibration, battery check
`timescale 1ns/1ps
module rtsup_top #(
  parameter int unsigned SLOW_QUAL_CYCLES = rtsup_pkg::SLOW_CYC,
  parameter int unsigned RESET_RECOVERY_TIME_CYCLES = rtsup_pkg::RESET_RECOVERY_TIME_CYC,
  parameter int unsigned DAY_SECONDS = rtsup_pkg::DAY_SECONDS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [19:0] i_axi_awaddr,
  input wire logic [2:0] i_axi_awprot,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // axi4-lite write response
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // axi4-lite read
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [19:0] i_axi_araddr,
  input wire logic [2:0] i_axi_arprot,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // oscillator edges, comparators, alarm flag
  input wire logic i_osc_edge,
  input wire logic i_power_fail,
  input wire logic i_battery_low,
  input wire logic i_alarm_flag,
  // reset inputs
  input wire logic i_quick_reset_n,
  input wire logic i_slow_reset_n,
  // open-drain reset output
  input wire logic i_reset_out_pin,
  output logic o_reset_out,
  output logic o_reset_out_oe,
  // open-drain interrupt and test pin
  input wire logic i_interrupt_calib_pin,
  output logic o_interrupt_calib_pin,
  output logic o_interrupt_calib_pin_oe,
  // square wave pin
  output logic o_square_wave_pin,
  output logic o_square_wave_pin_oe,
  // corrected one-second tick for the timekeeping counters
  output logic o_second_tick
);

  function automatic logic is_mapped(input logic [19:0] addr);
    is_mapped = (addr == rtsup_pkg::FLAGS_OFF) || (addr == rtsup_pkg::CTRL_OFF) ||
      (addr == rtsup_pkg::WDOG_OFF) || (addr == rtsup_pkg::MISC_OFF) ||
      (addr == rtsup_pkg::STAT_OFF);
  endfunction

  localparam int WD_ROUTE = rtsup_pkg::WD_ROUTE;

  logic aw_held, w_held;
  logic [19:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic wr_go, rd_go, rd_flags;
  logic [3:0] rate_sel;
  logic [7:0] ctrl, wdog;
  logic st, ft, afe, square_output_gate;
  logic dog_timeout_flag, bl, wd_irq;
  logic [15:0] div;
  logic [16:0] sec_cnt;
  logic [5:0] sec_in_min, min_in_cyc;
  logic [16:0] day_cnt;
  logic [10:0] wd_cnt;
  logic [2:0] qcnt;
  logic [20:0] scnt;
  logic [20:0] rec_cnt;
  logic pf_d;

  logic run_edge, wd_tick, wd_en, wd_expire, wr_wdog;
  logic quick_q, slow_q, hold_src, ext_reset, check_now;
  logic [10:0] wd_target;
  logic [16:0] sec_len;
  logic adj_second, irq_event, ft_on, sq_tap;

  assign wr_wdog = wr_go && (aw_addr == rtsup_pkg::WDOG_OFF) && w_lane0;
  assign run_edge = i_osc_edge && !st;
  assign wd_tick = run_edge && ((div[11:0] & rtsup_pkg::TICK16_MASK) == rtsup_pkg::TICK16_MASK);
  assign wd_en = (wdog[6:2] != 5'h0) && !wd_irq;
  assign wd_target = 11'({6'h00, wdog[6:2]} << {wdog[1:0], 1'b0});
  assign wd_expire = wd_en && wd_tick && ((wd_cnt + 11'h001) >= wd_target) && !wr_wdog;
  assign quick_q = (qcnt == 3'(rtsup_pkg::QUICK_CYC));
  assign slow_q = (scnt == 21'(SLOW_QUAL_CYCLES));
  assign ext_reset = quick_q || slow_q;
  assign hold_src = i_power_fail || ext_reset;
  assign check_now = (pf_d && !i_power_fail) ||
    (o_second_tick && (day_cnt == 17'(DAY_SECONDS - 1)));
  assign irq_event = wd_irq || (i_alarm_flag && afe);
  assign ft_on = !st && ft && !afe && (wdog[WD_ROUTE] || (wdog == 8'h00));
  assign adj_second = (sec_in_min == 6'h00) && (min_in_cyc < {ctrl[4:0], 1'b0});
  assign sec_len = !adj_second ? rtsup_pkg::SEC_EDGES :
    ctrl[rtsup_pkg::CAL_SIGN] ? rtsup_pkg::SEC_EDGES - rtsup_pkg::SEC_SHORT_EDGES :
    rtsup_pkg::SEC_EDGES + rtsup_pkg::SEC_LONG_EDGES;

  // square wave tap: code 1 is bit 0, codes 2 and up are bit n
  always_comb begin
    unique case (rate_sel)
      4'h0: sq_tap = 1'b0;
      4'h1: sq_tap = div[0];
      default: sq_tap = div[rate_sel];
    endcase
  end

  // axi write channels, taken in either order
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 20'h0_0000;
      w_data <= rtsup_pkg::REG_RESET;
      w_lane0 <= 1'b0;
      o_axi_awready <= 1'b1;
      o_axi_wready <= 1'b1;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= rtsup_pkg::RESP_OKAY;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_axi_awaddr;
        o_axi_awready <= 1'b0;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_held <= 1'b1;
        w_data <= i_axi_wdata[7:0];
        w_lane0 <= i_axi_wstrb[0];
        o_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= is_mapped(aw_addr) ? rtsup_pkg::RESP_OKAY : rtsup_pkg::RESP_SLVERR;
      end
      if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready <= 1'b1;
      end
    end
  end
  assign wr_go = aw_held && w_held && !o_axi_bvalid;

  // axi read channel; data captured once per access
  assign rd_go = i_axi_arvalid && o_axi_arready;
  assign rd_flags = rd_go && (i_axi_araddr == rtsup_pkg::FLAGS_OFF);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= rtsup_pkg::RESP_OKAY;
    end else if (rd_go) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b1;
      o_axi_rresp <= is_mapped(i_axi_araddr) ? rtsup_pkg::RESP_OKAY : rtsup_pkg::RESP_SLVERR;
      unique case (i_axi_araddr)
        rtsup_pkg::FLAGS_OFF:
          o_axi_rdata <= {24'h00_0000, dog_timeout_flag, i_alarm_flag, 1'b0, bl, rate_sel};
        rtsup_pkg::CTRL_OFF: o_axi_rdata <= {24'h00_0000, ctrl};
        rtsup_pkg::WDOG_OFF: o_axi_rdata <= {24'h00_0000, wdog};
        rtsup_pkg::MISC_OFF: o_axi_rdata <= {28'h000_0000, square_output_gate, afe, ft, st};
        rtsup_pkg::STAT_OFF:
          o_axi_rdata <= {26'h000_0000, wd_irq, i_power_fail, i_interrupt_calib_pin,
            i_reset_out_pin, o_interrupt_calib_pin_oe, o_reset_out_oe};
        default: o_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

  // flags, calibration and control bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_sel <= 4'h0;
      ctrl <= rtsup_pkg::REG_RESET;
      st <= 1'b0;
      ft <= 1'b0;
      afe <= 1'b0;
      square_output_gate <= 1'b0;
    end else begin
      if (wr_go && w_lane0 && aw_addr == rtsup_pkg::FLAGS_OFF) begin
        rate_sel <= w_data[3:0];
      end
      if (wr_go && w_lane0 && aw_addr == rtsup_pkg::CTRL_OFF) begin
        ctrl <= w_data;
      end
      if (wr_go && w_lane0 && aw_addr == rtsup_pkg::MISC_OFF) begin
        st <= w_data[rtsup_pkg::MISC_ST];
        ft <= w_data[rtsup_pkg::MISC_FT];
        afe <= w_data[rtsup_pkg::MISC_AFE];
        square_output_gate <= w_data[rtsup_pkg::MISC_SQUARE_OUTPUT_GATE];
      end
      if ((wd_expire && wdog[WD_ROUTE]) || ext_reset) begin
        ft <= 1'b0;
        afe <= 1'b0;
        square_output_gate <= 1'b0;
        ctrl[7:6] <= 2'h0;
      end
      if (i_power_fail) begin
        ft <= 1'b0;
        ctrl[7:6] <= 2'h0;
      end
    end
  end
  // watchdog register, up-counter and flag
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdog <= rtsup_pkg::REG_RESET;
      wd_cnt <= 11'h000;
      wd_irq <= 1'b0;
      dog_timeout_flag <= 1'b0;
    end else begin
      if (wr_wdog) begin
        wdog <= w_data;
        wd_cnt <= 11'h000;
        if (w_data == 8'h00) begin
          wd_irq <= 1'b0;
        end
      end else if (wd_expire) begin
        wd_cnt <= 11'h000;
        if (wdog[WD_ROUTE]) begin
          wdog <= rtsup_pkg::REG_RESET;
        end else begin
          wd_irq <= 1'b1;
        end
      end else if (wd_en && wd_tick) begin
        wd_cnt <= wd_cnt + 11'h001;
      end
      if (i_power_fail || ext_reset) begin
        wdog <= rtsup_pkg::REG_RESET;
        wd_cnt <= 11'h000;
        wd_irq <= 1'b0;
      end
      if (wd_expire) begin
        dog_timeout_flag <= 1'b1;
      end else if (rd_flags) begin
        dog_timeout_flag <= 1'b0;
      end
    end
  end

  // uncorrected divider chain and corrected seconds
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div <= 16'h0000;
      sec_cnt <= 17'h0_0000;
      sec_in_min <= 6'h00;
      min_in_cyc <= 6'h00;
      o_second_tick <= 1'b0;
    end else begin
      o_second_tick <= 1'b0;
      if (run_edge) begin
        div <= div + 16'h0001;
        if (sec_cnt >= sec_len - 17'h0_0001) begin
          sec_cnt <= 17'h0_0000;
          o_second_tick <= 1'b1;
          if (sec_in_min == rtsup_pkg::SEC_PER_MIN) begin
            sec_in_min <= 6'h00;
            min_in_cyc <= min_in_cyc + 6'h01;
          end else begin
            sec_in_min <= sec_in_min + 6'h01;
          end
        end else begin
          sec_cnt <= sec_cnt + 17'h0_0001;
        end
      end
    end
  end

  // battery checks at power-up and daily
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pf_d <= 1'b0;
      day_cnt <= 17'h0_0000;
      bl <= 1'b0;
    end else begin
      pf_d <= i_power_fail;
      if (o_second_tick) begin
        day_cnt <= (day_cnt == 17'(DAY_SECONDS - 1)) ? 17'h0_0000 : day_cnt + 17'h0_0001;
      end
      if (check_now) begin
        bl <= i_battery_low;
      end
    end
  end

  // reset input qualification and recovery timer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qcnt <= 3'h0;
      scnt <= 21'h00_0000;
      rec_cnt <= 21'h00_0000;
    end else begin
      if (i_quick_reset_n) begin
        qcnt <= 3'h0;
      end else if (!quick_q) begin
        qcnt <= qcnt + 3'h1;
      end
      if (i_slow_reset_n) begin
        scnt <= 21'h00_0000;
      end else if (!slow_q) begin
        scnt <= scnt + 21'h00_0001;
      end
      if (hold_src || (wd_expire && wdog[WD_ROUTE])) begin
        rec_cnt <= 21'(RESET_RECOVERY_TIME_CYCLES);
      end else if (rec_cnt != 21'h00_0000) begin
        rec_cnt <= rec_cnt - 21'h00_0001;
      end
    end
  end

  // pin drivers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reset_out <= 1'b0;
      o_reset_out_oe <= 1'b0;
      o_interrupt_calib_pin <= 1'b0;
      o_interrupt_calib_pin_oe <= 1'b0;
      o_square_wave_pin <= 1'b0;
      o_square_wave_pin_oe <= 1'b0;
    end else begin
      o_reset_out <= 1'b0;
      o_reset_out_oe <= hold_src || (rec_cnt != 21'h00_0000);
      o_interrupt_calib_pin <= 1'b0;
      if (irq_event) begin
        o_interrupt_calib_pin_oe <= 1'b1;
      end else if (ft_on) begin
        o_interrupt_calib_pin_oe <= !div[rtsup_pkg::FT_TAP];
      end else begin
        o_interrupt_calib_pin_oe <= 1'b0;
      end
      o_square_wave_pin <= sq_tap;
      o_square_wave_pin_oe <= square_output_gate && (rate_sel != 4'h0);
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_flag_read_clear: assert property (rd_flags && !wd_expire |=> !dog_timeout_flag)
    else $error("watchdog flag survived a flags read");
  a_powerdown_wdog: assert property (i_power_fail |=> wdog == 8'h00 && !ft)
    else $error("power-down left watchdog or test bit set");
  a_irq_priority: assert property (wd_irq |=> o_interrupt_calib_pin_oe)
    else $error("watchdog interrupt lost the shared pin");
  a_zero_release: assert property (wr_wdog && w_data == 8'h00 |=> !wd_irq ##1
    !o_interrupt_calib_pin_oe || (i_alarm_flag && afe) || ft_on)
    else $error("zero write did not release interrupt");
  a_quick_filter: assert property ($rose(quick_q) |-> $past(!i_quick_reset_n, 1) &&
    $past(!i_quick_reset_n, 2))
    else $error("quick reset qualified too soon");
  a_reset_hold: assert property ($fell(hold_src) |-> ##1 o_reset_out_oe[*8])
    else $error("reset released without recovery time");
  a_square_gate: assert property (!square_output_gate |=> !o_square_wave_pin_oe)
    else $error("square wave driven while gated off");
  a_weak_hold: assert property (bl && !check_now |=> bl)
    else $error("battery weak flag dropped without a check");
  a_ft_tap: assert property (ft_on && !irq_event |=>
    o_interrupt_calib_pin_oe == !$past(div[rtsup_pkg::FT_TAP]))
    else $error("frequency test not on the 512 Hz tap");

  c_wd_expire: cover property (wd_expire);
  c_reset_out: cover property ($rose(o_reset_out_oe));
  c_ft_toggle: cover property (ft_on ##1 $changed(o_interrupt_calib_pin_oe));
  c_flag_read: cover property (dog_timeout_flag ##1 rd_flags);

endmodule

// [rtl/rtsup_pkg.sv]
// constants shared by the supervisor support block
package rtsup_pkg;
  // register byte addresses
  localparam logic [19:0] FLAGS_OFF = 20'h7_fff0;
  localparam logic [19:0] CTRL_OFF = 20'h7_fff8;
  localparam logic [19:0] WDOG_OFF = 20'h7_ffe0;
  localparam logic [19:0] MISC_OFF = 20'h7_ffe4;
  localparam logic [19:0] STAT_OFF = 20'h7_ffe8;
  // field positions
  localparam int FLG_WDF = 7;
  localparam int FLG_AF = 6;
  localparam int FLG_BL = 4;
  localparam int CAL_SIGN = 5;
  localparam int WD_ROUTE = 7;
  localparam int MISC_ST = 0;
  localparam int MISC_FT = 1;
  localparam int MISC_AFE = 2;
  localparam int MISC_SQUARE_OUTPUT_GATE = 3;
  localparam int FT_TAP = 6;
  // reset value and bus response codes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int QUICK_MIN_NS = 50;
  localparam int QUICK_CYC = (QUICK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_MIN_MS = 20;
  localparam int SLOW_CYC = SLOW_MIN_MS * CLK_MHZ * 1000;
  localparam int RESET_RECOVERY_TIME_MS = 50;
  localparam int RESET_RECOVERY_TIME_CYC = RESET_RECOVERY_TIME_MS * CLK_MHZ * 1000;
  localparam int DAY_SECONDS = 86400;
  // divider chain counts edges of the crystal, two per oscillator cycle
  localparam int EDGES_PER_CYC = 2;
  localparam logic [16:0] SEC_EDGES = 17'h1_0000;
  localparam int OSC_CYC_SHORT = 128;
  localparam int OSC_CYC_LONG = 256;
  localparam logic [16:0] SEC_SHORT_EDGES = 17'(OSC_CYC_SHORT * EDGES_PER_CYC);
  localparam logic [16:0] SEC_LONG_EDGES = 17'(OSC_CYC_LONG * EDGES_PER_CYC);
  localparam logic [5:0] SEC_PER_MIN = 6'h3b;
  localparam logic [11:0] TICK16_MASK = 12'hfff;
endpackage

// [verification/rtsup_host_model.sv]
// host processor model driving the register bus
`timescale 1ns/1ps
module rtsup_host_model (
  // clock
  input wire logic i_mclk,
  // write side
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [19:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  input wire logic [1:0] i_bresp,
  // read side
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [19:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = 76'h0;
  end
  // one access at a time; each channel held until its own ready
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [31:0] din,
                      output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge i_mclk);
    if (wr) begin
      {o_awvalid, o_wvalid, o_bready} <= 3'h7;
      o_awaddr <= a;
      o_wdata <= din;
      o_wstrb <= 4'hf;
    end else begin
      {o_arvalid, o_rready} <= 2'h3;
      o_araddr <= a;
    end
    while (!got) begin
      @(posedge i_mclk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      got = wr ? (i_bvalid === 1'b1) : (i_rvalid === 1'b1);
      d = i_rdata;
      r = wr ? i_bresp : i_rresp;
    end
    {o_bready, o_rready} <= 2'h0;
  endtask
endmodule

// [verification/rtsup_top_tb.sv]
// self-checking bench for the supervisor support block
`timescale 1ns/1ps
module rtsup_top_tb;
  localparam int RESET_RECOVERY_TIME = 30;
  localparam int SLOWQ = 20;
  localparam logic [19:0] FLG = rtsup_pkg::FLAGS_OFF;
  localparam logic [19:0] CTL = rtsup_pkg::CTRL_OFF;
  localparam logic [19:0] WDG = rtsup_pkg::WDOG_OFF;
  localparam logic [19:0] MSC = rtsup_pkg::MISC_OFF;
  localparam logic [7:0] FT = 8'(1 << rtsup_pkg::MISC_FT);
  logic i_mclk;
  logic i_rst_n;
  logic osc_edge = 1'b0;
  logic power_fail, battery_low;
  logic [1:0] rst_in_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic rst_oe, irq_oe, sq_pin, sq_oe;
  int miscompares = 0;
  int check_count = 0;
  rtsup_host_model u_rtsup_host_model (
    .i_mclk(i_mclk), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr),
    .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb),
    .i_bvalid(bvalid), .o_bready(bready), .i_bresp(bresp), .o_arvalid(arvalid),
    .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid), .o_rready(rready),
    .i_rdata(rdata), .i_rresp(rresp)
  );
  rtsup_top #(.SLOW_QUAL_CYCLES(SLOWQ), .RESET_RECOVERY_TIME_CYCLES(RESET_RECOVERY_TIME), .DAY_SECONDS(3)) u_rtsup_top (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .o_axi_bresp(bresp), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .i_axi_araddr(araddr), .i_axi_arprot(3'h0), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_osc_edge(osc_edge),
    .i_power_fail(power_fail), .i_battery_low(battery_low), .i_alarm_flag(1'b0),
    .i_quick_reset_n(rst_in_n[1]), .i_slow_reset_n(rst_in_n[0]), .i_reset_out_pin(!rst_oe),
    .o_reset_out(), .o_reset_out_oe(rst_oe), .i_interrupt_calib_pin(!irq_oe),
    .o_interrupt_calib_pin(), .o_interrupt_calib_pin_oe(irq_oe),
    .o_square_wave_pin(sq_pin), .o_square_wave_pin_oe(sq_oe), .o_second_tick()
  );
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // crystal edge on every second clock
  always @(posedge i_mclk) osc_edge <= ~osc_edge;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [19:0] a, input logic [7:0] din,
                     output logic [7:0] d);
    logic [31:0] v;
    logic [1:0] r;
    u_rtsup_host_model.xfer(wr, a, {24'h00_0000, din}, v, r);
    check(r, rtsup_pkg::RESP_OKAY, "response");
    d = v[7:0];
  endtask
  // osc edges between two consecutive changes of the probed pin
  task automatic half_period(input logic irq, output int n);
    logic last;
    n = 0;
    @(posedge i_mclk);
    last = irq ? irq_oe : sq_pin;
    while ((irq ? irq_oe : sq_pin) === last) @(posedge i_mclk);
    last = irq ? irq_oe : sq_pin;
    while ((irq ? irq_oe : sq_pin) === last) begin
      n += int'(osc_edge);
      @(posedge i_mclk);
    end
  endtask
  task automatic hold_irq(input logic v, output int bad);
    bad = 0;
    repeat (4) @(posedge i_mclk);
    repeat (300) begin
      @(posedge i_mclk);
      bad += int'(irq_oe !== v);
    end
  endtask
  task automatic wait_hi(input logic irq, output int n);
    n = 0;
    while ((irq ? irq_oe : rst_oe) !== 1'b1 && n < 20000) begin
      @(posedge i_mclk);
      n++;
    end
  endtask
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] d;
    check({rst_oe, irq_oe, sq_oe}, 3'h0, "pins idle");
    acc(1'b0, CTL, 8'h00, d);
    check(d, 8'h00, "control reset");
    acc(1'b1, CTL, 8'h25, d);
    acc(1'b0, CTL, 8'h00, d);
    check(d, 8'h25, "calibration field");
    u_rtsup_host_model.xfer(1'b0, 20'h0_0100, 32'h0000_0000, v, r);
    check(r, rtsup_pkg::RESP_SLVERR, "unmapped read");
  endtask
  task automatic t_square();
    int n;
    logic [7:0] d;
    acc(1'b1, MSC, 8'(1 << rtsup_pkg::MISC_SQUARE_OUTPUT_GATE), d);
    for (int c = 0; c < 7; c++) begin
      acc(1'b1, FLG, 8'(c), d);
      repeat (4) @(posedge i_mclk);
      check(sq_oe, c != 0, "square drive");
      if (c != 0) begin
        half_period(1'b0, n);
        check(n, (c == 1) ? 1 : 1 << c, "square half period");
      end
    end
    acc(1'b1, MSC, 8'h00, d);
    repeat (4) @(posedge i_mclk);
    check(sq_oe, 1'b0, "gate off");
  endtask
  task automatic t_freq();
    int n;
    logic [7:0] d;
    acc(1'b1, MSC, FT, d);
    // let the test output settle before it is measured
    half_period(1'b1, n);
    half_period(1'b1, n);
    check(n, 64, "test half period");
    acc(1'b1, CTL, 8'h1f, d);
    half_period(1'b1, n);
    check(n, 64, "test after calibration");
    acc(1'b1, MSC, FT | 8'(1 << rtsup_pkg::MISC_AFE), d);
    hold_irq(1'b0, n);
    check(n, 0, "alarm enable blocks test");
    acc(1'b1, MSC, 8'h00, d);
  endtask
  task automatic t_watchdog();
    int n;
    logic [7:0] d;
    acc(1'b1, WDG, 8'h08, d);
    repeat (7000) @(posedge i_mclk);
    acc(1'b1, WDG, 8'h08, d);
    repeat (7000) @(posedge i_mclk);
    check(irq_oe, 1'b0, "restart delays timeout");
    wait_hi(1'b1, n);
    check(n < 9600, 1'b1, "timeout in time");
    acc(1'b1, MSC, FT, d);
    hold_irq(1'b1, n);
    check(n, 0, "interrupt wins pin");
    acc(1'b0, FLG, 8'h00, d);
    check(d[7], 1'b1, "timeout flag");
    acc(1'b0, FLG, 8'h00, d);
    check(d[7], 1'b0, "flag cleared by read");
    acc(1'b1, MSC, 8'h00, d);
    acc(1'b1, WDG, 8'h00, d);
    hold_irq(1'b0, n);
    check(n, 0, "zero write releases");
    acc(1'b1, WDG, 8'h84, d);
    wait_hi(1'b0, n);
    n = 0;
    while (rst_oe === 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      n++;
    end
    check(n, RESET_RECOVERY_TIME, "dog reset pulse");
    check(irq_oe, 1'b0, "routed away from irq");
  endtask
  task automatic t_reset_in(input int sel, input int qual);
    int hits;
    logic [7:0] d;
    hits = 0;
    acc(1'b1, WDG, 8'h08, d);
    rst_in_n[sel] <= 1'b0;
    repeat (qual - 1) @(posedge i_mclk);
    rst_in_n[sel] <= 1'b1;
    repeat (qual + 4) begin
      @(posedge i_mclk);
      hits += int'(rst_oe !== 1'b0);
    end
    check(hits, 0, "short pulse ignored");
    rst_in_n[sel] <= 1'b0;
    repeat (qual + 3) @(posedge i_mclk);
    check(rst_oe, 1'b1, "qualified low resets");
    rst_in_n[sel] <= 1'b1;
    repeat (RESET_RECOVERY_TIME - 2) @(posedge i_mclk);
    check(rst_oe, 1'b1, "reset held");
    repeat (6) @(posedge i_mclk);
    check(rst_oe, 1'b0, "reset released");
    acc(1'b0, WDG, 8'h00, d);
    check(d, 8'h00, "watchdog cleared");
  endtask
  task automatic t_power();
    logic [7:0] d;
    battery_low <= 1'b1;
    acc(1'b1, WDG, 8'h08, d);
    acc(1'b1, MSC, FT, d);
    acc(1'b0, FLG, 8'h00, d);
    check(d[4], 1'b0, "no check yet");
    for (int k = 0; k < 2; k++) begin
      power_fail <= 1'b1;
      repeat (3) @(posedge i_mclk);
      check(rst_oe, 1'b1, "power fail resets");
      power_fail <= 1'b0;
      repeat (RESET_RECOVERY_TIME - 2) @(posedge i_mclk);
      check(rst_oe, 1'b1, "held after power-up");
      repeat (6) @(posedge i_mclk);
      check(rst_oe, 1'b0, "released after power-up");
      acc(1'b0, FLG, 8'h00, d);
      check(d[4], k == 0, "weak battery flag");
      battery_low <= 1'b0;
      acc(1'b0, FLG, 8'h00, d);
      check(d[4], k == 0, "flag kept between checks");
    end
    acc(1'b0, WDG, 8'h00, d);
    check(d, 8'h00, "watchdog cleared at power-down");
    acc(1'b0, MSC, 8'h00, d);
    check(d & FT, 8'h00, "test bit cleared at power-down");
  endtask
  initial begin
    i_rst_n = 1'b0;
    power_fail = 1'b0;
    battery_low = 1'b0;
    rst_in_n = 2'h3;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_square();
    t_freq();
    t_watchdog();
    t_reset_in(1, 2);
    t_reset_in(0, SLOWQ);
    t_power();
    test_done();
  end
  initial begin
    #4_000_000;
    miscompares++;
    test_done();
  end
endmodule
